// file: bench/link_peer.sv
module link_peer (
   input wire logic frame,
   output logic sck_pin,
   output logic nss_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Peer master: clock only inside frames
   // ----------------------------------------
   initial begin
      sck_pin = 1'b0;
      nss_pin = 1'b1;
      forever begin
         wait (frame);
         #13 nss_pin = 1'b0;
         while (frame) begin
            #40 sck_pin = ~sck_pin;
         end
         // Select has a pull-up, clock parks low
         sck_pin = 1'b0;
         nss_pin = 1'b1;
      end
   end
endmodule // link_peer

// file: bench/spi_irq_chk.sv
module spi_irq_chk #(
   parameter int FIFO_DEPTH = 4,
   parameter int CW = 3
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire spi_irq_pkg::core_t core,
   input wire logic [CW-1:0] tx_count,
   input wire logic [CW-1:0] rx_count,
   input wire logic sck_pin,
   input wire logic nss_pin,
   input wire logic tx_flush,
   input wire logic ss_out_n,
   input wire logic ss_oe,
   input wire logic tx_dma_req,
   input wire logic rx_dma_req,
   input wire logic port_irq,
   input wire logic evt_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Shadow of the control enables
   // ----------------------------------------
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic acc;
   logic flush_req;
   logic rx_nz;
   logic en_any;
   logic i2s;
   assign acc = psel && penable;
   assign flush_req = acc && pwrite && paddr == spi_irq_pkg::CTRL_OFS && pwdata[4]
      && !core.port_enable;
   assign rx_nz = rx_count != '0;
   assign en_any = |ctrl_q[7:5];
   assign i2s = core.i2s_mode;
   always_comb begin
      ctrl_d = ctrl_q;
      if (acc && pwrite && paddr == spi_irq_pkg::CTRL_OFS) begin
         ctrl_d = pwdata[7:0] & spi_irq_pkg::CTRL_WMASK[7:0];
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_FLUSH_GO: assert property (flush_req |=> tx_flush ##1 !tx_flush)
      else $error("flush pulse wrong");
   AST_FLUSH_WHY: assert property (tx_flush |-> $past(flush_req))
      else $error("flush without allowed write");
   AST_SS_OE: assert property (ss_oe |-> core.master_mode && !core.i2s_mode)
      else $error("select driven outside master mode");
   AST_SS_PIN: assert property (ss_out_n == !(ss_oe && core.port_enable))
      else $error("select pin level wrong");
   AST_RSVD: assert property (acc && !pwrite && paddr == spi_irq_pkg::CTRL_OFS
      |-> prdata[31:8] == 24'h0 && !prdata[3]) else $error("reserved bits not zero");
   AST_I2S_LVL: assert property (acc && !pwrite && paddr == spi_irq_pkg::STAT_OFS
      && i2s && $past(i2s) && $past(i2s, 2) && $past(i2s, 3) |-> prdata[12:9] == 4'h0)
      else $error("levels shown in i2s mode");
   AST_RX_IRQ: assert property (ctrl_q[6] && $past(ctrl_q[6])
      && rx_nz && $past(rx_nz) && $past(rx_nz, 2) |-> port_irq)
      else $error("rx interrupt missing");
   AST_IRQ_QUIET: assert property (!en_any && !$past(en_any) |-> !port_irq)
      else $error("interrupt with all sources off");
   AST_RX_DMA: assert property (ctrl_q[0] && $past(ctrl_q[0]) && rx_nz
      && !$past(rx_nz) |-> ##2 rx_dma_req ##1 !rx_dma_req) else $error("rx dma pulse wrong");
   AST_TX_DMA_ONE: assert property (tx_dma_req |=> !tx_dma_req)
      else $error("tx dma longer than one cycle");
endmodule // spi_irq_chk

// file: bench/spi_irq_dma_status_control_tb.sv
module spi_irq_dma_status_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, frame, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] tx_count, rx_count;
   logic sck_pin, nss_pin, tx_flush, ss_out_n, ss_oe, tx_dma_req, rx_dma_req, port_irq;
   logic evt_irq;
   spi_irq_pkg::core_t core;
   int fails, n_checks, n_flush, n_tdma, n_rdma;
   logic [1:0] lv [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
   spi_irq_dma_status_control #(.FIFO_DEPTH(4)) u_dut (.clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .core, .tx_count, .rx_count, .sck_pin,
      .nss_pin, .tx_flush, .ss_out_n, .ss_oe, .tx_dma_req, .rx_dma_req, .port_irq, .evt_irq);
   link_peer u_peer (.frame, .sck_pin, .nss_pin);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      n_flush <= n_flush + int'(tx_flush);
      n_tdma <= n_tdma + int'(tx_dma_req);
      n_rdma <= n_rdma + int'(rx_dma_req);
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         fails++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rd, exp);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Pulses overflow, checksum or data-read events for one cycle
   task automatic pulse(input logic [2:0] m);
      core.ovr_evt <= m[0];
      core.crc_evt <= m[1];
      core.dr_read <= m[2];
      @(posedge clk);
      core.ovr_evt <= 1'b0;
      core.crc_evt <= 1'b0;
      core.dr_read <= 1'b0;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, frame} = 4'h0;
      {paddr, pwdata, tx_count, rx_count} = 46'h0;
      core = '0;
      {fails, n_checks, n_flush, n_tdma, n_rdma} = '0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rdc("ctrl reset", spi_irq_pkg::CTRL_OFS, 32'h0);
      rdc("status reset", spi_irq_pkg::STAT_OFS, 32'h2);
      check("irq off", port_irq, 1'b0);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'hffff_fff7);
      wt(3);
      check("flush", n_flush, 1);
      check("tx dma", n_tdma, 1);
      check("tx irq", port_irq, 1'b1);
      rdc("ctrl rw", spi_irq_pkg::CTRL_OFS, 32'he7);
      core.port_enable <= 1'b1;
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h10);
      wt(3);
      check("flush refused", n_flush, 1);
      check("tx irq masked", port_irq, 1'b0);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h41);
      rx_count <= 3'h1;
      wt(12);
      check("rx irq", port_irq, 1'b1);
      check("rx dma once", n_rdma, 1);
      rdc("rx status", spi_irq_pkg::STAT_OFS, 32'h203);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h01);
      rx_count <= 3'h0;
      wt(3);
      rx_count <= 3'h2;
      wt(4);
      check("rx irq masked", port_irq, 1'b0);
      check("rx dma again", n_rdma, 2);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h02);
      rx_count <= 3'h0;
      for (int i = 0; i < 5; i++) begin
         tx_count <= 3'(i);
         wt(3);
         rdc("tx level", spi_irq_pkg::STAT_OFS,
            {19'h0, lv[i], 3'h0, i != 0, 5'h0, i == 0, 1'b0});
      end
      for (int i = 0; i < 5; i++) begin
         tx_count <= 3'h0;
         rx_count <= 3'(i);
         wt(3);
         rdc("rx level", spi_irq_pkg::STAT_OFS, {21'h0, lv[i], 7'h0, 1'b1, i != 0});
      end
      check("tx dma rise", n_tdma, 3);
      tx_count <= 3'h3;
      core.i2s_mode <= 1'b1;
      wt(4);
      rdc("i2s level", spi_irq_pkg::STAT_OFS, 32'h81);
      core.i2s_mode <= 1'b0;
      core.crc_rx_only <= 1'b1;
      wt(4);
      rdc("crc rx level", spi_irq_pkg::STAT_OFS, 32'h1881);
      core.crc_rx_only <= 1'b0;
      {tx_count, rx_count} <= 6'h0;
      wt(6);
      apb(1'b0, spi_irq_pkg::EVT_OFS, 32'h0);
      apb(1'b1, spi_irq_pkg::MASK_OFS, 32'h04);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h20);
      pulse(3'h1);
      wt(3);
      check("fault irq", port_irq, 1'b1);
      check("event irq", evt_irq, 1'b1);
      rdc("event read", spi_irq_pkg::EVT_OFS, 32'h04);
      rdc("ovr set", spi_irq_pkg::STAT_OFS, 32'h42);
      check("event cleared", evt_irq, 1'b0);
      pulse(3'h4);
      wt(3);
      rdc("ovr clear", spi_irq_pkg::STAT_OFS, 32'h02);
      check("fault irq off", port_irq, 1'b0);
      apb(1'b1, spi_irq_pkg::MASK_OFS, 32'h0);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h0);
      pulse(3'h2);
      wt(3);
      check("masked irqs", port_irq | evt_irq, 1'b0);
      rdc("crc set", spi_irq_pkg::STAT_OFS, 32'h12);
      apb(1'b1, spi_irq_pkg::STAT_OFS, 32'hffff_ffff);
      rdc("crc kept", spi_irq_pkg::STAT_OFS, 32'h12);
      apb(1'b1, spi_irq_pkg::STAT_OFS, 32'h0);
      rdc("crc clear", spi_irq_pkg::STAT_OFS, 32'h02);
      core.master_mode <= 1'b1;
      frame <= 1'b1;
      wt(100);
      rdc("link busy", spi_irq_pkg::STAT_OFS, 32'ha2);
      frame <= 1'b0;
      wt(80);
      rdc("fault held", spi_irq_pkg::STAT_OFS, 32'h22);
      apb(1'b1, spi_irq_pkg::CTRL_OFS, 32'h04);
      rdc("fault clear", spi_irq_pkg::STAT_OFS, 32'h02);
      check("select drive", {ss_oe, ss_out_n}, 2'h2);
      core.i2s_mode <= 1'b1;
      wt(2);
      check("select i2s", {ss_oe, ss_out_n}, 2'h1);
      apb(1'b0, 8'h0c, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      close_out();
   end
endmodule // spi_irq_dma_status_control_tb

bind spi_irq_dma_status_control spi_irq_chk #(.FIFO_DEPTH(FIFO_DEPTH), .CW(CW)) u_chk (
   .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .core, .tx_count, .rx_count, .sck_pin, .nss_pin, .tx_flush, .ss_out_n, .ss_oe,
   .tx_dma_req, .rx_dma_req, .port_irq, .evt_irq);

// file: hw/spi_irq_dma_status_control.sv
// Operation
// - With tx_empty_irq_enable set, tx_empty_flag at 1 requests an interrupt, else not.
// - With rx_avail_irq_enable set, rx_avail_flag at 1 requests an interrupt, else masked.
// - fault_irq_enable gates checksum, overflow and mode fault onto the interrupt.
// - Writing 1 to tx_queue_flush empties the transmit queue, then the bit returns to 0.
// - A tx_queue_flush write is ignored while port_enable is 1.
// - select_output_enable in master mode drives the select pin; unused in I2S mode.
// - tx_dma_request_enable issues a request each time tx_empty_flag becomes set.
// - rx_dma_request_enable issues a request each time rx_avail_flag becomes set.
// - tx_queue_level shows empty, quarter, half or full (above half), zero in I2S mode.
// - rx_queue_level shows the receive fill level, zero in I2S or CRC receive-only mode.
// - transfer_active is 1 while a transfer runs or the transmit buffer holds data.
// - overflow_flag is set by hardware and cleared by a status read then a data read.
// - mode_fault_flag is read-only, set by hardware on a mode fault, cleared by a status read then a control write.
// - checksum_mismatch_flag is set on CRC mismatch, cleared by writing 0, kept by 1.
// - tx_empty_flag is 1 while the transmit buffer is empty and comes out of reset at 1.
module spi_irq_dma_status_control #(
   parameter int FIFO_DEPTH = 4,
   parameter int CW = $clog2(FIFO_DEPTH) + 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire spi_irq_pkg::core_t core,
   input wire logic [CW-1:0] tx_count,
   input wire logic [CW-1:0] rx_count,
   input wire logic sck_pin,
   input wire logic nss_pin,
   output logic tx_flush,
   output logic ss_out_n,
   output logic ss_oe,
   output logic tx_dma_req,
   output logic rx_dma_req,
   output logic port_irq,
   output logic evt_irq
);
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic acc;
   logic setup;
   logic hit;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic rd_stat;
   logic rd_evt;

   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign hit = (paddr == spi_irq_pkg::CTRL_OFS) || (paddr == spi_irq_pkg::STAT_OFS) ||
                (paddr == spi_irq_pkg::EVT_OFS) || (paddr == spi_irq_pkg::MASK_OFS);
   assign pready = acc;
   assign pslverr = acc & ~hit;
   assign wr_ctrl = acc & pwrite & (paddr == spi_irq_pkg::CTRL_OFS);
   assign wr_stat = acc & pwrite & (paddr == spi_irq_pkg::STAT_OFS);
   assign wr_mask = acc & pwrite & (paddr == spi_irq_pkg::MASK_OFS);
   assign rd_stat = acc & ~pwrite & (paddr == spi_irq_pkg::STAT_OFS);
   assign rd_evt = acc & ~pwrite & (paddr == spi_irq_pkg::EVT_OFS);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic sck_s1_q;
   logic sck_s2_q;
   logic sck_s3_q;
   logic nss_s1_q;
   logic nss_s2_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         nss_s1_q <= 1'b1;
         nss_s2_q <= 1'b1;
      end else begin
         sck_s1_q <= sck_pin;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         nss_s1_q <= nss_pin;
         nss_s2_q <= nss_s1_q;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [spi_irq_pkg::EVT_W-1:0] mask_q;
   logic [spi_irq_pkg::EVT_W-1:0] mask_d;

   always_comb begin
      ctrl_d = ctrl_q;
      ctrl_d[spi_irq_pkg::C_FLUSH] = 1'b0;
      mask_d = mask_q;
      if (wr_ctrl) begin
         ctrl_d = pwdata[15:0] & spi_irq_pkg::CTRL_WMASK;
         // Flush only while the port is off
         ctrl_d[spi_irq_pkg::C_FLUSH] =
            pwdata[spi_irq_pkg::C_FLUSH] & ~core.port_enable;
      end
      if (wr_mask) begin
         mask_d = pwdata[spi_irq_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= spi_irq_pkg::CTRL_RST;
         mask_q <= spi_irq_pkg::EVT_RST;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
      end
   end

   assign tx_flush = ctrl_q[spi_irq_pkg::C_FLUSH];

   // ----------------------------------------
   // Select output
   // ----------------------------------------
   logic ss_en;

   assign ss_en = core.master_mode & ctrl_q[spi_irq_pkg::C_SELECT_OUTPUT_ENABLE] & ~core.i2s_mode;
   assign ss_oe = ss_en;
   assign ss_out_n = ~(ss_en & core.port_enable);

   // ----------------------------------------
   // Buffer flags and link activity
   // ----------------------------------------
   logic txe_q;
   logic rx_avail_flag_q;
   logic txe_d;
   logic rx_avail_flag_d;
   logic [7:0] idle_q;
   logic [7:0] idle_d;
   logic busy;

   always_comb begin
      txe_d = (tx_count == '0);
      rx_avail_flag_d = (rx_count != '0);
      idle_d = idle_q;
      // Link clock may stop between frames, so hold busy for a short tail
      if (sck_s2_q != sck_s3_q) begin
         idle_d = 8'(spi_irq_pkg::LINK_IDLE_CYC);
      end else if (idle_q != 8'h00) begin
         idle_d = idle_q - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txe_q <= 1'b1;
         rx_avail_flag_q <= 1'b0;
         idle_q <= 8'h00;
      end else begin
         txe_q <= txe_d;
         rx_avail_flag_q <= rx_avail_flag_d;
         idle_q <= idle_d;
      end
   end

   assign busy = core.core_busy | ~txe_q | (idle_q != 8'h00);

   // ----------------------------------------
   // Error flags
   // ----------------------------------------
   logic ovr_q;
   logic ovr_d;
   logic mode_fault_flag_q;
   logic mode_fault_flag_d;
   logic crc_q;
   logic crc_d;
   logic mode_fault_flag_set;
   spi_irq_pkg::seq_t ovr_seq_q;
   spi_irq_pkg::seq_t ovr_seq_d;
   spi_irq_pkg::seq_t mode_fault_flag_seq_q;
   spi_irq_pkg::seq_t mode_fault_flag_seq_d;

   // Another master pulled select low while ours is not driven
   assign mode_fault_flag_set = core.master_mode & core.port_enable & ~ss_en & ~nss_s2_q;

   always_comb begin
      ovr_d = ovr_q;
      ovr_seq_d = ovr_seq_q;
      case (ovr_seq_q)
         spi_irq_pkg::SEQ_IDLE: begin
            if (rd_stat && ovr_q) begin
               ovr_seq_d = spi_irq_pkg::SEQ_ARMED;
            end
         end
         spi_irq_pkg::SEQ_ARMED: begin
            if (core.dr_read) begin
               ovr_d = 1'b0;
               ovr_seq_d = spi_irq_pkg::SEQ_IDLE;
            end
         end
         default: begin
            ovr_seq_d = spi_irq_pkg::SEQ_IDLE;
         end
      endcase
      if (core.ovr_evt) begin
         ovr_d = 1'b1;
      end
   end

   always_comb begin
      mode_fault_flag_d = mode_fault_flag_q;
      mode_fault_flag_seq_d = mode_fault_flag_seq_q;
      case (mode_fault_flag_seq_q)
         spi_irq_pkg::SEQ_IDLE: begin
            if (rd_stat && mode_fault_flag_q) begin
               mode_fault_flag_seq_d = spi_irq_pkg::SEQ_ARMED;
            end
         end
         spi_irq_pkg::SEQ_ARMED: begin
            if (wr_ctrl) begin
               mode_fault_flag_d = 1'b0;
               mode_fault_flag_seq_d = spi_irq_pkg::SEQ_IDLE;
            end
         end
         default: begin
            mode_fault_flag_seq_d = spi_irq_pkg::SEQ_IDLE;
         end
      endcase
      if (mode_fault_flag_set) begin
         mode_fault_flag_d = 1'b1;
      end
   end

   always_comb begin
      crc_d = crc_q;
      if (wr_stat && !pwdata[spi_irq_pkg::S_CRC]) begin
         crc_d = 1'b0;
      end
      if (core.crc_evt) begin
         crc_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ovr_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         crc_q <= 1'b0;
         ovr_seq_q <= spi_irq_pkg::SEQ_IDLE;
         mode_fault_flag_seq_q <= spi_irq_pkg::SEQ_IDLE;
      end else begin
         ovr_q <= ovr_d;
         mode_fault_flag_q <= mode_fault_flag_d;
         crc_q <= crc_d;
         ovr_seq_q <= ovr_seq_d;
         mode_fault_flag_seq_q <= mode_fault_flag_seq_d;
      end
   end

   // ----------------------------------------
   // Fill levels and status word
   // ----------------------------------------
   function automatic logic [1:0] fill_level(input logic [CW-1:0] cnt);
      logic [CW+1:0] c4;
      c4 = {cnt, 2'b00};
      if (cnt == '0) begin
         fill_level = spi_irq_pkg::LVL_EMPTY;
      end else if (c4 <= (CW+2)'(FIFO_DEPTH)) begin
         fill_level = spi_irq_pkg::LVL_QUART;
      end else if (c4 <= (CW+2)'(2 * FIFO_DEPTH)) begin
         fill_level = spi_irq_pkg::LVL_HALF;
      end else begin
         fill_level = spi_irq_pkg::LVL_FULL;
      end
   endfunction

   logic [15:0] stat_val;

   always_comb begin
      stat_val = 16'h0000;
      if (!core.i2s_mode) begin
         stat_val[spi_irq_pkg::S_TXLVL +: 2] = fill_level(tx_count);
         if (!core.crc_rx_only) begin
            stat_val[spi_irq_pkg::S_RXLVL +: 2] = fill_level(rx_count);
         end
      end
      stat_val[spi_irq_pkg::S_BSY] = busy;
      stat_val[spi_irq_pkg::S_OVR] = ovr_q;
      stat_val[spi_irq_pkg::S_MODE_FAULT_FLAG] = mode_fault_flag_q;
      stat_val[spi_irq_pkg::S_CRC] = crc_q;
      stat_val[spi_irq_pkg::S_TXE] = txe_q;
      stat_val[spi_irq_pkg::S_RX_AVAIL_FLAG] = rx_avail_flag_q;
   end

   // ----------------------------------------
   // DMA requests and interrupts
   // ----------------------------------------
   logic txd_lvl;
   logic rxd_lvl;
   logic txd_lvl_q;
   logic rxd_lvl_q;
   logic txd_req_q;
   logic rxd_req_q;
   logic txe_prev_q;
   logic rx_avail_flag_prev_q;
   logic [spi_irq_pkg::EVT_W-1:0] evt_q;
   logic [spi_irq_pkg::EVT_W-1:0] evt_d;
   logic [spi_irq_pkg::EVT_W-1:0] evt_set;
   logic port_irq_q;
   logic evt_irq_q;
   logic irq_lvl;

   // Enabling with the flag already up also counts as the flag becoming set
   assign txd_lvl = ctrl_q[spi_irq_pkg::C_TXDMA] & txe_q;
   assign rxd_lvl = ctrl_q[spi_irq_pkg::C_RXDMA] & rx_avail_flag_q;

   assign irq_lvl = (ctrl_q[spi_irq_pkg::C_TX_EMPTY_IRQ_ENABLE] & txe_q) |
                    (ctrl_q[spi_irq_pkg::C_RX_AVAIL_IRQ_ENABLE] & rx_avail_flag_q) |
                    (ctrl_q[spi_irq_pkg::C_FAULT_IRQ_ENABLE] & (ovr_q | mode_fault_flag_q | crc_q));

   always_comb begin
      evt_set = '0;
      evt_set[spi_irq_pkg::E_TXE] = txe_q & ~txe_prev_q;
      evt_set[spi_irq_pkg::E_RX_AVAIL_FLAG] = rx_avail_flag_q & ~rx_avail_flag_prev_q;
      evt_set[spi_irq_pkg::E_OVR] = core.ovr_evt;
      evt_set[spi_irq_pkg::E_MODE_FAULT_FLAG] = mode_fault_flag_set & ~mode_fault_flag_q;
      evt_set[spi_irq_pkg::E_CRC] = core.crc_evt;
      // Set wins over the read clear
      evt_d = (rd_evt ? '0 : evt_q) | evt_set;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txd_lvl_q <= 1'b0;
         rxd_lvl_q <= 1'b0;
         txd_req_q <= 1'b0;
         rxd_req_q <= 1'b0;
         txe_prev_q <= 1'b1;
         rx_avail_flag_prev_q <= 1'b0;
         evt_q <= spi_irq_pkg::EVT_RST;
         port_irq_q <= 1'b0;
         evt_irq_q <= 1'b0;
      end else begin
         txd_lvl_q <= txd_lvl;
         rxd_lvl_q <= rxd_lvl;
         txd_req_q <= txd_lvl & ~txd_lvl_q;
         rxd_req_q <= rxd_lvl & ~rxd_lvl_q;
         txe_prev_q <= txe_q;
         rx_avail_flag_prev_q <= rx_avail_flag_q;
         evt_q <= evt_d;
         port_irq_q <= irq_lvl;
         evt_irq_q <= |(evt_q & mask_q);
      end
   end

   assign tx_dma_req = txd_req_q;
   assign rx_dma_req = rxd_req_q;
   assign port_irq = port_irq_q;
   assign evt_irq = evt_irq_q;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   always_comb begin
      prdata_d = prdata_q;
      if (setup && !pwrite) begin
         case (paddr)
            spi_irq_pkg::CTRL_OFS: prdata_d = {16'h0000, ctrl_q};
            spi_irq_pkg::STAT_OFS: prdata_d = {16'h0000, stat_val};
            spi_irq_pkg::EVT_OFS: prdata_d = {27'h0, evt_q};
            spi_irq_pkg::MASK_OFS: prdata_d = {27'h0, mask_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;

endmodule // spi_irq_dma_status_control

// file: pkg/spi_irq_pkg.sv
package spi_irq_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] EVT_OFS = 8'h14;
   localparam logic [7:0] MASK_OFS = 8'h18;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int C_TX_EMPTY_IRQ_ENABLE = 7;
   localparam int C_RX_AVAIL_IRQ_ENABLE = 6;
   localparam int C_FAULT_IRQ_ENABLE = 5;
   localparam int C_FLUSH = 4;
   localparam int C_SELECT_OUTPUT_ENABLE = 2;
   localparam int C_TXDMA = 1;
   localparam int C_RXDMA = 0;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h00f7;
   // ----------------------------------------
   // Status fields
   // ----------------------------------------
   localparam int S_TXLVL = 11;
   localparam int S_RXLVL = 9;
   localparam int S_BSY = 7;
   localparam int S_OVR = 6;
   localparam int S_MODE_FAULT_FLAG = 5;
   localparam int S_CRC = 4;
   localparam int S_TXE = 1;
   localparam int S_RX_AVAIL_FLAG = 0;
   localparam logic [1:0] LVL_EMPTY = 2'h0;
   localparam logic [1:0] LVL_QUART = 2'h1;
   localparam logic [1:0] LVL_HALF = 2'h2;
   localparam logic [1:0] LVL_FULL = 2'h3;
   // ----------------------------------------
   // Event register fields
   // ----------------------------------------
   localparam int EVT_W = 5;
   localparam int E_TXE = 0;
   localparam int E_RX_AVAIL_FLAG = 1;
   localparam int E_OVR = 2;
   localparam int E_MODE_FAULT_FLAG = 3;
   localparam int E_CRC = 4;
   localparam logic [EVT_W-1:0] EVT_RST = 5'h00;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 4;
   localparam int LINK_IDLE_NS = 160;
   localparam int LINK_IDLE_CYC = (LINK_IDLE_NS + CLK_NS - 1) / CLK_NS;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic port_enable;
      logic master_mode;
      logic i2s_mode;
      logic crc_rx_only;
      logic core_busy;
      logic ovr_evt;
      logic crc_evt;
      logic dr_read;
   } core_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_ARMED = 2'b01
   } seq_t;
endpackage
